// ---- bench/hfosc_ctrl_bench.sv ----
// Self-checking bench for the oscillator control block.
// Assumes the checker is bound and the oscillator model sits on the far side.
`timescale 1ns/1ps
`default_nettype none
module hfosc_ctrl_bench;
  import hfosc_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, tick, tclk, run, dith, ctick, on, pin_in, pin_out, dig, d2;
  logic [3:0] adr, sel, wake;
  logic [31:0] dat, rdat, q;
  logic [2:0] mode, drv;
  int bad_count, checks_done, n;
  hfosc_ctrl i_hfosc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .osc_tick_i(tick),
    .wake_event_i(wake), .wake_timer_clk_i(tclk), .osc_run_o(run), .dither_enable_o(dith), .core_tick_o(ctick),
    .ext_osc_mode_select_o(mode), .ext_osc_drive_select_o(drv), .ext_osc_on_o(on), .osc_in_pin_used_o(pin_in),
    .osc_out_pin_used_o(pin_out), .osc_pin_digital_o(dig), .ext_div2_o(d2));
  hfosc_osc_model i_hfosc_osc_model (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .osc_tick_o(tick),
    .timer_clk_o(tclk));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Comparison with counting
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Classic single Wishbone cycle, held until ack
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Register fields, unused bit and refused writes
  task automatic t_regs;
    wb(4'h0, 1'b1, 32'h0000_00df, 4'h1);
    wb(4'h0, 1'b0, 32'h0, 4'hf);
    chk("ctrl", q, 32'h0000_000b);
    chk("dither", {31'h0, dith}, 32'h1);
    wb(4'h0, 1'b1, 32'h0000_0000, 4'he);
    wb(4'h0, 1'b0, 32'h0, 4'hf);
    chk("sel0 off", q, 32'h0000_000b);
    // Only bit 2 set: must read back as all zero
    wb(4'h0, 1'b1, 32'h0000_0004, 4'h1);
    wb(4'h0, 1'b0, 32'h0, 4'hf);
    chk("ctrl clr", q, 32'h0);
    chk("dither off", {31'h0, dith}, 32'h0);
    wb(4'hc, 1'b0, 32'h0, 4'hf);
    chk("unmapped", q, 32'h0);
  endtask
  // Core clock ratio for every divide code
  task automatic t_div;
    for (int c = 0; c < 4; c++) begin
      wb(4'h0, 1'b1, 32'(c), 4'h1);
      n = 0;
      repeat (128) @(posedge clk_i) n += int'(ctick);
      chk("div", {31'h0, n >= (8 << c) - 1 && n <= (8 << c)}, 32'h1);
    end
  endtask
  // Suspend, then wake by the one source given, which is the timer when src is 0
  task automatic t_susp(input int src);
    wb(4'h0, 1'b1, 32'h0000_0020, 4'h1);
    chk("halted", {31'h0, run}, 32'h0);
    wb(4'h0, 1'b0, 32'h0, 4'hf);
    chk("susp bit", q, 32'h0000_0020);
    wake <= 4'h1 << src;
    repeat (8) if (run !== 1'b1) @(posedge clk_i);
    chk("woken", {31'h0, run}, 32'h1);
    // Wake cause register keeps the vector that ended suspend
    wb(4'h8, 1'b0, 32'h0, 4'hf);
    chk("cause", q, 32'(4'h1 << src));
    wb(4'h0, 1'b0, 32'h0, 4'hf);
    chk("sync set", q[4], src != 0);
    for (int i = 0; i < 20 && q[4] !== 1'b0; i++) wb(4'h0, 1'b0, 32'h0, 4'hf);
    chk("sync clear", q, 32'h0);
    wake <= 4'h0;
    repeat (6) @(posedge clk_i);
  endtask
  // Every external mode and its pin takeover
  task automatic t_ext;
    for (int m = 0; m < 8; m++) begin
      // Type and drive go together in one write before any use
      wb(4'h4, 1'b1, 32'(m << 4 | 5), 4'h1);
      wb(4'h4, 1'b0, 32'h0, 4'hf);
      chk("ext", q, 32'(m << 4 | 5));
      chk("mode", {29'h0, mode}, 32'(m));
      // Pin flags tell software which pins to skip and how to set them up
      chk("pins", {27'h0, on, pin_in, pin_out, dig, d2},
        {27'h0, m > 1, m > 5, m > 1, m / 2 == 1, m % 4 == 3});
      chk("drive", {29'h0, drv}, 32'h5);
    end
  endtask
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    sel = 4'h0;
    dat = 32'h0;
    wake = 4'h0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("run rst", {31'h0, run}, 32'h1);
    wb(4'h0, 1'b0, 32'h0, 4'hf);
    chk("ctrl rst", q, 32'h0);
    t_regs();
    t_div();
    t_susp(1);
    t_susp(0);
    t_ext();
    print_verdict();
  end
  // Hang guard, far beyond the under one thousand cycles the tests need
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire

// ---- bench/hfosc_ctrl_chk.sv ----
// Port checker for the oscillator control block.
// Assumes one clock domain with sync active-high reset.
`timescale 1ns/1ps
`default_nettype none
module hfosc_ctrl_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic osc_run_o,
  input wire logic dither_enable_o,
  input wire logic ext_osc_on_o,
  input wire logic ext_div2_o,
  input wire logic osc_in_pin_used_o,
  input wire logic osc_out_pin_used_o,
  input wire logic osc_pin_digital_o,
  input wire logic [2:0] ext_osc_mode_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Accepted write to the internal control register
  wire wr0 = wb_ack_o && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0];
  a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_suspend_halts: assert property (wr0 && wb_dat_i[5] |-> !osc_run_o) else $error("no halt");
  a_halt_by_write: assert property ($fell(osc_run_o) |-> wr0 && wb_dat_i[5]) else $error("stray halt");
  a_dither_follows: assert property (wr0 |=> ##1 dither_enable_o == $past(wb_dat_i[3], 2))
    else $error("dither");
  a_unused_bits_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |-> wb_dat_o[2] == 1'b0)
    else $error("bit2 set");
  a_xtal_two_pins: assert property (osc_in_pin_used_o == ($past(ext_osc_mode_select_o) >= 3'h6))
    else $error("in pin");
  a_out_pin_used: assert property (osc_out_pin_used_o == ($past(ext_osc_mode_select_o) >= 3'h2) &&
    ext_osc_on_o == osc_out_pin_used_o) else $error("out pin");
  a_mode_decode: assert property (osc_pin_digital_o == ($past(ext_osc_mode_select_o) >> 1 == 3'h1) &&
    ext_div2_o == (($past(ext_osc_mode_select_o) & 3'h3) == 3'h3)) else $error("mode decode");
  c_suspend: cover property (wr0 && wb_dat_i[5]);
  c_wake: cover property ($rose(osc_run_o));
  c_xtal: cover property (osc_in_pin_used_o);
endmodule
bind hfosc_ctrl hfosc_ctrl_chk i_hfosc_ctrl_chk (.*);
`default_nettype wire

// ---- bench/hfosc_osc_model.sv ----
// Oscillator side model: tick source and free wake timer clock.
// Assumes the bench ties run_i to the block's run output.
`timescale 1ns/1ps
`default_nettype none
module hfosc_osc_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic osc_tick_o,
  output logic timer_clk_o
);
  // Tick every other cycle, silent while halted
  always_ff @(posedge clk_i) begin
    osc_tick_o <= !rst_i && run_i && !osc_tick_o;
  end
  // Slow timer clock, unrelated in phase to clk_i
  initial begin
    timer_clk_o = 1'b0;
    forever #26 timer_clk_o = ~timer_clk_o;
  end
endmodule
`default_nettype wire

// ---- logic/hfosc_clk_div.sv ----
// Divider from internal oscillator enable ticks to core clock enable.
// Assumes osc_tick_i is a one-cycle pulse per oscillator period.
`timescale 1ns/1ps
`default_nettype none
module hfosc_clk_div
  import hfosc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic osc_tick_i,
  input wire logic [1:0] sel_i,
  output logic core_tick_o
);
  // All state in one struct
  typedef struct packed {
    logic [2:0] cnt;
    logic tick;
  } hfosc_div_st_t;
  hfosc_div_st_t st_q, st_d;
  logic [2:0] last; // Terminal count for chosen ratio

  // Ratio decode and count
  always_comb begin
    st_d = st_q;
    case (sel_i)
      2'h0: last = 3'h7;
      2'h1: last = 3'h3;
      2'h2: last = 3'h1;
      default: last = 3'h0;
    endcase
    st_d.tick = 1'b0;
    if (osc_tick_i) begin
      if (st_q.cnt >= last) begin
        // Also recovers when ratio shrinks mid-count
        st_d.cnt = 3'h0;
        st_d.tick = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + 3'h1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign core_tick_o = st_q.tick;
endmodule
`default_nettype wire

// ---- logic/hfosc_ctrl.sv ----
// Internal oscillator suspend, dither and divider control plus external
// oscillator pin takeover, reached over classic Wishbone.
// Assumes wake events and timer ticks come from pins or other domains.
// Core clock leaves as a tick enable; no second clock is made here.
// Suspend also gates that enable, so downstream logic simply stalls.
`timescale 1ns/1ps
`default_nettype none
module hfosc_ctrl
  import hfosc_pkg::*;
#(
  parameter int WAKE_SRCS = 4 // Wake event lines, index 0 is the wake timer
)(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Oscillator side
  input wire logic osc_tick_i,
  input wire logic [WAKE_SRCS-1:0] wake_event_i,
  input wire logic wake_timer_clk_i,
  output logic osc_run_o,
  output logic dither_enable_o,
  output logic core_tick_o,
  output logic [2:0] ext_osc_mode_select_o,
  output logic [2:0] ext_osc_drive_select_o,
  output logic ext_osc_on_o,
  output logic osc_in_pin_used_o,
  output logic osc_out_pin_used_o,
  output logic osc_pin_digital_o,
  output logic ext_div2_o
);
  // Entire module state
  typedef struct packed {
    hfosc_state_t fsm;
    logic dither;
    logic [1:0] div_sel;
    logic [2:0] mode;
    logic [2:0] drive;
    logic [WAKE_SRCS-1:0] wake_s1; // First sync stage, read only by second
    logic [WAKE_SRCS-1:0] wake_s2;
    logic [WAKE_SRCS-1:0] wake_seen; // Sticky record of last wake cause
    logic [2:0] tclk_sync; // Timer clock synchroniser plus edge history
    logic [1:0] sync_cnt; // Timer clocks left before timer is safe
    logic ack;
    logic [31:0] rdata;
    hfosc_pins_t pins;
  } hfosc_st_t;
  hfosc_st_t st_q, st_d;

  logic bus_req; // Live request without pending ack
  logic wr_hf; // Write strobe to control register
  logic wr_ext; // Write strobe to external control
  logic any_wake; // Some synced wake event
  logic tclk_rise; // Synced timer clock edge
  logic [7:0] hf_rd; // Control register read image
  logic [7:0] ext_rd; // External control read image

  // Only byte lane 0 carries register bits, so sel[0] gates writes
  assign bus_req = wb_cyc_i && wb_stb_i && !st_q.ack;
  assign wr_hf = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == HFOSC_OFF_HF_CTRL;
  assign wr_ext = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == HFOSC_OFF_EXT_CTRL;
  assign any_wake = |st_q.wake_s2;
  // Timer clock is only edge-counted, never used to clock anything
  assign tclk_rise = st_q.tclk_sync[1] && !st_q.tclk_sync[2];

  // Read images; control bit 2, external bit 3 and upper bits stay zero
  always_comb begin
    hf_rd = 8'h00;
    hf_rd[HFOSC_BIT_SUSPEND] = (st_q.fsm == HFOSC_SUSP);
    hf_rd[HFOSC_BIT_SYNC] = (st_q.fsm == HFOSC_SYNC);
    hf_rd[HFOSC_BIT_DITHER] = st_q.dither;
    hf_rd[HFOSC_BIT_DIV_LO +: 2] = st_q.div_sel;
    ext_rd = 8'h00;
    ext_rd[HFOSC_BIT_MODE_LO +: 3] = st_q.mode;
    ext_rd[HFOSC_BIT_DRIVE_LO +: 3] = st_q.drive;
  end

  // Next-state logic for bus, suspend and pins
  always_comb begin
    st_d = st_q;
    // Two-flop synchronisers for outside signals
    // Stage one feeds stage two only, keeping metastability contained
    st_d.wake_s1 = wake_event_i;
    st_d.wake_s2 = st_q.wake_s1;
    st_d.tclk_sync = {st_q.tclk_sync[1:0], wake_timer_clk_i};
    // Bus: single-wait-state ack, dropped the cycle after
    st_d.ack = bus_req;
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        HFOSC_OFF_HF_CTRL: st_d.rdata = {24'h0, hf_rd};
        HFOSC_OFF_EXT_CTRL: st_d.rdata = {24'h0, ext_rd};
        HFOSC_OFF_WAKE_SRC: st_d.rdata = 32'(st_q.wake_seen);
        default: st_d.rdata = 32'h0; // Unmapped reads zero, still acked
      endcase
    end
    if (wr_hf) begin
      st_d.dither = wb_dat_i[HFOSC_BIT_DITHER];
      st_d.div_sel = wb_dat_i[HFOSC_BIT_DIV_LO +: 2];
    end
    if (wr_ext) begin
      // Software sets type and drive together before use
      st_d.mode = wb_dat_i[HFOSC_BIT_MODE_LO +: 3];
      st_d.drive = wb_dat_i[HFOSC_BIT_DRIVE_LO +: 3];
    end
    // Suspend sequencing
    case (st_q.fsm)
      HFOSC_RUN: begin
        if (wr_hf && wb_dat_i[HFOSC_BIT_SUSPEND]) begin
          st_d.fsm = HFOSC_SUSP;
        end
      end
      HFOSC_SUSP: begin
        if (any_wake) begin
          // Cause stays readable until the next wake
          st_d.wake_seen = st_q.wake_s2;
          // Timer wake needs no resync; others do
          if (st_q.wake_s2[0]) begin
            st_d.fsm = HFOSC_RUN;
          end else begin
            st_d.fsm = HFOSC_SYNC;
            st_d.sync_cnt = 2'(HFOSC_SYNC_TIMER_CLOCKS - 1);
          end
        end
      end
      HFOSC_SYNC: begin
        // Oscillator already running; only timer access is fenced
        if (wr_hf && wb_dat_i[HFOSC_BIT_SUSPEND]) begin
          // A new suspend request must still halt the oscillator
          st_d.fsm = HFOSC_SUSP;
        end else if (tclk_rise) begin
          if (st_q.sync_cnt == 2'h0) begin
            st_d.fsm = HFOSC_RUN;
          end else begin
            st_d.sync_cnt = st_q.sync_cnt - 2'h1;
          end
        end
      end
      default: st_d.fsm = HFOSC_RUN;
    endcase
    // Pin takeover decode
    // Registered, so pad muxes never see a decode glitch;
    // the price is one cycle of lag after a mode write
    st_d.pins = '0;
    case (st_q.mode)
      HFOSC_XM_XTAL, HFOSC_XM_XTAL_DIV2: begin
        st_d.pins.in_pin_used = 1'b1;
        st_d.pins.out_pin_used = 1'b1;
        st_d.pins.div2 = st_q.mode[0];
      end
      HFOSC_XM_RC, HFOSC_XM_CAP: begin
        st_d.pins.out_pin_used = 1'b1;
      end
      HFOSC_XM_CMOS, HFOSC_XM_CMOS_DIV2: begin
        st_d.pins.out_pin_used = 1'b1;
        st_d.pins.cmos_input = 1'b1;
        st_d.pins.div2 = st_q.mode[0];
      end
      default: st_d.pins = '0; // Codes 00x: circuit off
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Field reset values come from the package
      st_q <= '0;
      st_q.fsm <= HFOSC_RUN;
      st_q.div_sel <= HFOSC_RST_DIV;
      st_q.mode <= HFOSC_RST_MODE;
      st_q.drive <= HFOSC_RST_DRIVE;
    end else begin
      st_q <= st_d;
    end
  end

  // Core clock divider, gated off while suspended
  // Gating the enable rather than a clock keeps one domain
  hfosc_clk_div u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .osc_tick_i(osc_tick_i && st_q.fsm != HFOSC_SUSP),
    .sel_i(st_q.div_sel),
    .core_tick_o(core_tick_o)
  );

  // Outputs; crossbar skipping is left to software via pin flags
  assign wb_ack_o = st_q.ack;
  assign wb_dat_o = st_q.rdata;
  assign osc_run_o = st_q.fsm != HFOSC_SUSP;
  assign dither_enable_o = st_q.dither;
  assign ext_osc_mode_select_o = st_q.mode;
  assign ext_osc_drive_select_o = st_q.drive;
  // Every enabled mode uses the output pin, so it doubles as on flag
  assign ext_osc_on_o = st_q.pins.out_pin_used;
  assign osc_in_pin_used_o = st_q.pins.in_pin_used;
  assign osc_out_pin_used_o = st_q.pins.out_pin_used;
  assign osc_pin_digital_o = st_q.pins.cmos_input;
  assign ext_div2_o = st_q.pins.div2;
endmodule
`default_nettype wire

// ---- logic/hfosc_pkg.sv ----
// Constants and carrier types for the oscillator control block.
// Assumes a single 125 MHz clock domain and a classic Wishbone register bus.
package hfosc_pkg;
  // Register byte offsets on the bus
  localparam logic [3:0] HFOSC_OFF_HF_CTRL = 4'h0; // Internal oscillator control
  localparam logic [3:0] HFOSC_OFF_EXT_CTRL = 4'h4; // External oscillator control
  localparam logic [3:0] HFOSC_OFF_WAKE_SRC = 4'h8; // Wake event status
  // Field positions in hf_osc_control
  localparam int HFOSC_BIT_SUSPEND = 5;
  localparam int HFOSC_BIT_SYNC = 4;
  localparam int HFOSC_BIT_DITHER = 3;
  localparam int HFOSC_BIT_DIV_LO = 0;
  // Field positions in ext_osc_control
  localparam int HFOSC_BIT_MODE_LO = 4;
  localparam int HFOSC_BIT_DRIVE_LO = 0;
  // Reset values
  localparam logic [1:0] HFOSC_RST_DIV = 2'h0;
  localparam logic [2:0] HFOSC_RST_MODE = 3'h0;
  localparam logic [2:0] HFOSC_RST_DRIVE = 3'h0;
  // Sync flag hold, in wake timer clocks
  localparam int HFOSC_SYNC_TIMER_CLOCKS = 3;
  // External oscillator modes
  localparam logic [2:0] HFOSC_XM_CMOS = 3'h2;
  localparam logic [2:0] HFOSC_XM_CMOS_DIV2 = 3'h3;
  localparam logic [2:0] HFOSC_XM_RC = 3'h4;
  localparam logic [2:0] HFOSC_XM_CAP = 3'h5;
  localparam logic [2:0] HFOSC_XM_XTAL = 3'h6;
  localparam logic [2:0] HFOSC_XM_XTAL_DIV2 = 3'h7;
  // Suspend state machine
  typedef enum logic [1:0] {
    HFOSC_RUN,
    HFOSC_SUSP,
    HFOSC_SYNC
  } hfosc_state_t;
  // Pin usage carrier
  typedef struct packed {
    logic in_pin_used;  // osc_in_pin taken over
    logic out_pin_used; // osc_out_pin taken over
    logic cmos_input;   // Pin wants a digital input
    logic div2;         // Divide-by-2 stage active
  } hfosc_pins_t;
endpackage
